/* src/uaf_defines.svh */
// Register offsets, field positions and reset values of the address filter.
// Assumes byte addressing on a 32-bit APB bus, one register per word.
// Functional notes
// - Filtering only while multiprocessor enable set
// - Filtering: flag only on address match
// - 8-bit mode: stop bit acts as ninth
// - 8-bit mode: valid stop always needed, plus a match while filtering
// - Accept given or broadcast address match
// - Shift mode ignores multiprocessor enable entirely
// - Given address: own address, mask zeros free
`ifndef UAF_DEFINES_SVH
`define UAF_DEFINES_SVH

// Byte offsets
`define UAF_SERIAL_CONTROL_OFS 8'h00
`define UAF_OWN_ADDRESS_OFS 8'h04
`define UAF_ADDRESS_MASK_OFS 8'h08
`define UAF_STATUS_OFS 8'h0C
`define UAF_RX_DATA_OFS 8'h10

// Serial control fields
`define UAF_MODE_LSB 0
`define UAF_MODE_MSB 1
`define UAF_MP_ENABLE_BIT 2

// Status fields
`define UAF_DONE_BIT 0
`define UAF_NOT_EMPTY_BIT 1
`define UAF_FULL_BIT 2

// Receive data field
`define UAF_NINTH_BIT 8

// Reset values
`define UAF_CONTROL_RST 3'h0
`define UAF_OWN_ADDRESS_RST 8'h00
`define UAF_ADDRESS_MASK_RST 8'h00

// Buffer depth
`define UAF_FIFO_DEPTH 8

`endif

/* src/uaf_pkg.sv */
// Types shared by the address filter and its buffer.
// Assumes uaf_defines.svh sits on the include path.
package uaf_pkg;

	// Serial port operating modes, in field order
	typedef enum logic [1:0] {
		UAF_MODE_SHIFT,
		UAF_MODE_8BIT,
		UAF_MODE_9BIT_FIXED,
		UAF_MODE_9BIT_VAR
	} uaf_mode_e;

	// One received frame from the deserialiser
	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} uaf_frame_s;

endpackage

/* src/uaf_filter.sv */
// Receive address filter with APB registers and an accepted-frame FIFO.
// Assumes frames arrive already deserialised, synchronous to clk;
// ninth carries the ninth data bit, or the stop bit in 8-bit mode.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "uaf_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, flip-flop storage
module uaf_fifo
	import uaf_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = `UAF_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Pointers need a power of two to wrap cleanly
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
			$error("uaf_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire empty = (wr_ptr == rd_ptr);
	wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);

	// Handshake flags
	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rd_ptr[AW-1:0]];

	// Storage needs no reset; only pointers do
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	// Pointer update
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= wr_ptr + (AW+1)'(push);
			rd_ptr <= rd_ptr + (AW+1)'(pop);
		end
	end

	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (sys_rst)
		full |-> !push)
		else $error("fifo written while full");
	a_fifo_no_underrun: assert property (@(posedge clk) disable iff (sys_rst)
		empty |-> !pop)
		else $error("fifo read while empty");
endmodule

////////////////////////////////////////////////////////////////////////////
// Address filter top
module uaf_filter
	import uaf_pkg::*;
#(
	parameter int DEPTH = `UAF_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Received frames from the deserialiser
	input wire logic rx_valid,
	output logic rx_ready,
	input wire uaf_frame_s rx_frame,
	// Receive complete flag, level
	output logic receive_done_flag
);
	localparam int FW = $bits(uaf_frame_s);

	initial begin
		if (DEPTH < 2)
			$error("uaf_filter: DEPTH must be at least 2");
	end

	// Address compare: bits where care is zero are free
	function automatic logic addr_hit(input logic [7:0] addr,
		input logic [7:0] ref_addr, input logic [7:0] care);
		addr_hit = ((addr ^ ref_addr) & care) == 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [1:0] mode_field;
	logic multiprocessor_enable;
	logic [7:0] own_address_reg;
	logic [7:0] address_mask_reg;
	uaf_mode_e mode;
	assign mode = uaf_mode_e'(mode_field);

	// APB decode; zero wait states so the access edge is the answer
	wire apb_acc = psel & penable;
	wire apb_wr = apb_acc & pwrite;
	wire apb_rd = apb_acc & ~pwrite;
	wire sel_ctrl = (paddr == `UAF_SERIAL_CONTROL_OFS);
	wire sel_own = (paddr == `UAF_OWN_ADDRESS_OFS);
	wire sel_mask = (paddr == `UAF_ADDRESS_MASK_OFS);
	wire sel_stat = (paddr == `UAF_STATUS_OFS);
	wire sel_data = (paddr == `UAF_RX_DATA_OFS);
	wire mapped = sel_ctrl | sel_own | sel_mask | sel_stat | sel_data;
	assign pready = 1'b1;
	assign pslverr = apb_acc & ~mapped;

	// Control registers written by software
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			{multiprocessor_enable, mode_field} <= `UAF_CONTROL_RST;
			own_address_reg <= `UAF_OWN_ADDRESS_RST;
			address_mask_reg <= `UAF_ADDRESS_MASK_RST;
		end else if (apb_wr) begin
			if (sel_ctrl) begin
				mode_field <= pwdata[`UAF_MODE_MSB:`UAF_MODE_LSB];
				multiprocessor_enable <= pwdata[`UAF_MP_ENABLE_BIT];
			end
			if (sel_own)
				own_address_reg <= pwdata[7:0];
			if (sel_mask)
				address_mask_reg <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Filter decision
	wire filt_on = multiprocessor_enable && (mode != UAF_MODE_SHIFT);
	wire [7:0] bcast_addr = own_address_reg | address_mask_reg;
	wire given_hit = addr_hit(rx_frame.data, own_address_reg,
		address_mask_reg);
	wire bcast_hit = addr_hit(rx_frame.data, bcast_addr, bcast_addr);
	wire any_hit = given_hit | bcast_hit;
	// Stop bit plays the ninth bit's part in 8-bit mode
	wire marker = rx_frame.ninth;
	wire mode8 = (mode == UAF_MODE_8BIT);
	// Address frame in 9-bit modes only when ninth bit set
	wire filt_accept = marker && any_hit;
	// Unfiltered: 8-bit mode still drops frames with a bad stop bit
	wire open_accept = mode8 ? marker : 1'b1;
	wire accept = filt_on ? filt_accept : open_accept;

	// Frames are taken only when the buffer has room, so a slow
	// reader stalls the deserialiser instead of losing data
	wire fifo_in_ready;
	wire take = rx_valid & rx_ready;
	assign rx_ready = fifo_in_ready;
	wire push_ok = take & accept;

	////////////////////////////////////////////////////////////////////////
	// Accepted frame buffer; a data read drains it
	wire fifo_out_valid;
	wire [FW-1:0] fifo_out_data;
	wire pop = apb_rd & sel_data & fifo_out_valid;
	uaf_fifo #(
		.WIDTH(FW),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(rx_valid & accept),
		.in_ready(fifo_in_ready),
		.in_data(rx_frame),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);
	wire fifo_full = ~fifo_in_ready;

	////////////////////////////////////////////////////////////////////////
	// Receive complete flag: write one to clear, a new frame wins
	wire done_clr = apb_wr & sel_stat & pwdata[`UAF_DONE_BIT];
	logic next_done;
	assign next_done = push_ok | (receive_done_flag & ~done_clr);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			receive_done_flag <= 1'b0;
		else
			receive_done_flag <= next_done;
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux from register state
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux[`UAF_MODE_MSB:`UAF_MODE_LSB] = mode_field;
			rd_mux[`UAF_MP_ENABLE_BIT] = multiprocessor_enable;
		end
		if (sel_own)
			rd_mux[7:0] = own_address_reg;
		if (sel_mask)
			rd_mux[7:0] = address_mask_reg;
		if (sel_stat) begin
			rd_mux[`UAF_DONE_BIT] = receive_done_flag;
			rd_mux[`UAF_NOT_EMPTY_BIT] = fifo_out_valid;
			rd_mux[`UAF_FULL_BIT] = fifo_full;
		end
		if (sel_data && fifo_out_valid)
			rd_mux[`UAF_NINTH_BIT:0] = fifo_out_data;
	end
	assign prdata = apb_rd ? rd_mux : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_shift_mode_open: assert property (@(posedge clk) disable iff (sys_rst)
		(take && mode == UAF_MODE_SHIFT) |-> push_ok)
		else $error("shift mode frame dropped");
	a_filter_gate: assert property (@(posedge clk) disable iff (sys_rst)
		(take && !multiprocessor_enable && mode != UAF_MODE_8BIT)
		|-> push_ok)
		else $error("frame filtered without enable");
	a_flag_on_match: assert property (@(posedge clk) disable iff (sys_rst)
		(take && filt_on && marker && any_hit) |=> receive_done_flag)
		else $error("matching frame did not raise flag");
	a_no_flag_miss: assert property (@(posedge clk) disable iff (sys_rst)
		(filt_on && take && !any_hit && !receive_done_flag)
		|=> !receive_done_flag)
		else $error("flag raised by foreign address");
	a_stop_bit_need: assert property (@(posedge clk) disable iff (sys_rst)
		(take && mode8 && !rx_frame.ninth) |-> !push_ok)
		else $error("8-bit frame with bad stop accepted");
	a_given_match: assert property (@(posedge clk) disable iff (sys_rst)
		(filt_on && take && marker &&
		(((rx_frame.data ^ own_address_reg) & address_mask_reg) == 8'h00))
		|-> push_ok)
		else $error("given address match refused");
	a_bcast_match: assert property (@(posedge clk) disable iff (sys_rst)
		(filt_on && take && marker && ((rx_frame.data & bcast_addr)
		== bcast_addr)) |-> push_ok)
		else $error("broadcast match refused");
	a_data_frame_drop: assert property (@(posedge clk) disable iff (sys_rst)
		(filt_on && take && !mode8 && !rx_frame.ninth) |-> !push_ok)
		else $error("data frame accepted while filtering");
	a_set_beats_clr: assert property (@(posedge clk) disable iff (sys_rst)
		(push_ok && done_clr) |=> receive_done_flag)
		else $error("clear beat a new frame");
	a_clear_flag: assert property (@(posedge clk) disable iff (sys_rst)
		(done_clr && !push_ok) |=> !receive_done_flag)
		else $error("flag not cleared");


	// Flag is sticky: only a clear drops it, only a push raises it
	a_flag_holds: assert property (@(posedge clk) disable iff (sys_rst)
		(receive_done_flag && !done_clr) |=> receive_done_flag)
		else $error("flag dropped without clear");
	a_flag_only_push: assert property (@(posedge clk) disable iff (sys_rst)
		(!receive_done_flag && !push_ok) |=> !receive_done_flag)
		else $error("flag raised without accepted frame");

	// In 8-bit mode a good stop bit stands in for the ninth bit
	a_mode8_stop_ok: assert property (@(posedge clk) disable iff (sys_rst)
		(take && filt_on && mode8 && rx_frame.ninth && any_hit)
		|-> push_ok)
		else $error("8-bit matching frame refused");

	// Register writes land at the access edge
	a_mask_written: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_wr && sel_mask) |=> address_mask_reg == 8'($past(pwdata)))
		else $error("mask write lost");
	a_own_written: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_wr && sel_own) |=> own_address_reg == 8'($past(pwdata)))
		else $error("own address write lost");
	a_ctrl_written: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_wr && sel_ctrl)
		|=> {multiprocessor_enable, mode_field} == 3'($past(pwdata)))
		else $error("control write lost");

	// Unmapped accesses must not disturb state and must signal error
	a_bad_addr_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_wr && !mapped)
		|=> $stable(own_address_reg) && $stable(address_mask_reg))
		else $error("unmapped write changed a register");
	a_unmapped_error: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_acc && !mapped) |-> pslverr)
		else $error("unmapped access without error");

	// Bus answer shape; software relies on zero wait states
	a_zero_wait: assert property (@(posedge clk) disable iff (sys_rst)
		apb_acc |-> pready)
		else $error("access not answered at once");
	a_prdata_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!apb_rd |-> prdata == 32'h0000_0000)
		else $error("read data outside a read");
	a_empty_read_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_rd && sel_data && !fifo_out_valid) |-> prdata == 32'h0000_0000)
		else $error("empty buffer read not zero");

	// Stalling follows buffer room, so no frame is ever lost
	a_ready_tracks_room: assert property (@(posedge clk) disable iff (sys_rst)
		rx_ready == !fifo_full)
		else $error("ready disagrees with buffer room");
	a_status_level: assert property (@(posedge clk) disable iff (sys_rst)
		(apb_rd && sel_stat)
		|-> prdata[`UAF_NOT_EMPTY_BIT] == fifo_out_valid)
		else $error("status not-empty bit wrong");

	// Main scenarios worth seeing at least once
	c_addr_accept: cover property (@(posedge clk) disable iff (sys_rst)
		filt_on && push_ok && given_hit);
	c_mode8_accept: cover property (@(posedge clk) disable iff (sys_rst)
		filt_on && mode8 && push_ok);
	c_bcast_only: cover property (@(posedge clk) disable iff (sys_rst)
		filt_on && push_ok && bcast_hit && !given_hit);
	c_rejected: cover property (@(posedge clk) disable iff (sys_rst)
		filt_on && take && !accept);
	c_fifo_full: cover property (@(posedge clk) disable iff (sys_rst)
		rx_valid && fifo_full);
endmodule

/* test/uaf_node_model.sv */
// Far-side node model: queues frames and offers them one at a time.
// Assumes the filter takes a frame at an edge with rx_valid and rx_ready.
`timescale 1ns/1ps

module uaf_node_model
	import uaf_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Stall control from the bench
	input wire logic hold,
	// Frame stream
	output logic rx_valid,
	input wire logic rx_ready,
	output uaf_frame_s rx_frame,
	// Queue empty and nothing on offer
	output logic idle
);
	uaf_frame_s q[$];
	uaf_frame_s last;
	logic offer;

	////////////////////////////////////////////////////////////////////////
	// Queue a frame for sending
	task automatic send(input uaf_frame_s f);
		q.push_back(f);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Offer held until taken; idle lines show inverse of the last frame
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_valid <= 1'b0;
			rx_frame <= 9'h1FF;
			last = 9'h000;
			idle <= 1'b1;
		end else begin
			if (rx_valid && rx_ready)
				last = q.pop_front();
			offer = (rx_valid && !rx_ready) || (!hold && q.size() > 0);
			rx_valid <= offer;
			rx_frame <= offer ? q[0] : ~last;
			idle <= !offer && q.size() == 0;
		end
	end
endmodule

/* test/uaf_filter_test.sv */
// Self-checking bench of the address filter, registers over APB.
// Assumes uaf_defines.svh on the include path and the node model.
`timescale 1ns/1ps
`include "uaf_defines.svh"

module uaf_filter_test
	import uaf_pkg::*;
;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic rx_valid, rx_ready, receive_done_flag, hold, idle, er;
	uaf_frame_s rx_frame;
	int n_errors, tests_run, cycles;

	uaf_filter #(.DEPTH(8)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame(rx_frame),
		.receive_done_flag(receive_done_flag));
	uaf_node_model node (.clk(clk), .sys_rst(sys_rst), .hold(hold),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_frame(rx_frame),
		.idle(idle));

	////////////////////////////////////////////////////////////////////////
	// Clock and timeout; the ceiling is far above the run's length
	always #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, bus cycle and frame tasks
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait for the answer; only the bench timeout ends a hang
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task cfg(input logic [2:0] c, input logic [7:0] own, input logic [7:0] m);
		apb(1'b1, `UAF_SERIAL_CONTROL_OFS, {29'h0, c});
		apb(1'b1, `UAF_OWN_ADDRESS_OFS, {24'h0, own});
		apb(1'b1, `UAF_ADDRESS_MASK_OFS, {24'h0, m});
	endtask

	// Clear the flag, send one frame, check flag and buffered data
	task try_frame(input logic [8:0] f, input logic acc);
		apb(1'b1, `UAF_STATUS_OFS, 32'h1);
		node.send(f);
		// Let the model register the offer before polling idle
		repeat (2) @(posedge clk);
		while (!idle)
			@(posedge clk);
		repeat (2) @(posedge clk);
		chk({31'h0, receive_done_flag}, {31'h0, acc});
		rdc(`UAF_STATUS_OFS, acc ? 32'h3 : 32'h0);
		if (acc)
			rdc(`UAF_RX_DATA_OFS, {23'h0, f});
	endtask

	task stop_test();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{clk, psel, penable, pwrite, hold} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(`UAF_SERIAL_CONTROL_OFS, 32'h0);
		rdc(`UAF_ADDRESS_MASK_OFS, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test reset_and_map done");
		cfg(3'h4, 8'h56, 8'hFF);
		try_frame(9'h012, 1'b1);
		cfg(3'h7, 8'h56, 8'hFC);
		try_frame(9'h055, 1'b0);
		try_frame(9'h157, 1'b1);
		try_frame(9'h158, 1'b0);
		try_frame(9'h1FF, 1'b1);
		try_frame(9'h1FE, 1'b1);
		try_frame(9'h1FC, 1'b0);
		cfg(3'h6, 8'h56, 8'hFC);
		try_frame(9'h154, 1'b1);
		cfg(3'h7, 8'h56, 8'hFF);
		try_frame(9'h157, 1'b0);
		try_frame(9'h156, 1'b1);
		cfg(3'h5, 8'h56, 8'hFF);
		try_frame(9'h056, 1'b0);
		try_frame(9'h157, 1'b0);
		try_frame(9'h156, 1'b1);
		cfg(3'h3, 8'h56, 8'hFF);
		try_frame(9'h0AA, 1'b1);
		$display("test filtering done");
		// Fill past depth while the node stalls, then drain in order
		cfg(3'h2, 8'h00, 8'h00);
		hold <= 1'b1;
		for (int i = 0; i < 9; i++)
			node.send({1'b0, i[7:0]});
		repeat (3) @(posedge clk);
		hold <= 1'b0;
		repeat (14) @(posedge clk);
		chk({31'h0, rx_ready}, 32'h0);
		rdc(`UAF_STATUS_OFS, 32'h7);
		for (int i = 0; i < 9; i++)
			rdc(`UAF_RX_DATA_OFS, {24'h0, i[7:0]});
		rdc(`UAF_RX_DATA_OFS, 32'h0);
		rdc(`UAF_STATUS_OFS, 32'h1);
		$display("test buffer done");
		stop_test();
	end
endmodule
